// *** shared/hlec_pkg.sv ***
// Shared constants and carrier types for the home logic event counter
package hlec_pkg;

   // ****************************************************************
   // Event codes and unit masks
   // ****************************************************************
   localparam logic [7:0] EV_SNOOP               = 8'h0c;
   localparam logic [7:0] EV_REQUEST             = 8'h20;
   localparam logic [7:0] EV_FULL                = 8'h21;
   localparam logic [7:0] EV_BUSY                = 8'h22;
   localparam logic [7:0] EV_OCCUPANCY           = 8'h23;
   localparam logic [7:0] EV_CONFLICT            = 8'h24;
   localparam logic [7:0] UMASK_SNOOP_INVALIDATE = 8'h08;
   localparam logic [7:0] UMASK_TWO_WAY          = 8'h02;

   // ****************************************************************
   // Prior line state, one-hot as in the filter mask
   // ****************************************************************
   localparam logic [3:0] STATE_MODIFIED  = 4'h1;
   localparam logic [3:0] STATE_EXCLUSIVE = 4'h2;
   localparam logic [3:0] STATE_SHARED    = 4'h4;
   localparam logic [3:0] STATE_FORWARD   = 4'h8;
   localparam logic [3:0] STATE_NONE      = 4'h0;

   // ****************************************************************
   // Trackers and conflict table
   // ****************************************************************
   localparam int         TRACKERS       = 3;
   localparam logic [1:0] TWO_WAY_LIMIT  = 2'h2;
   localparam logic [1:0] CONFLICT_SAT   = 2'h3;
   localparam logic [1:0] CONFLICT_NONE  = 2'h0;
   localparam logic [1:0] CONFLICT_STEP  = 2'h1;

   typedef enum logic [1:0] {
      SRC_IO_HUB,
      SRC_REMOTE,
      SRC_LOCAL
   } hlec_source_type;

   typedef struct packed {
      logic [7:0] event_code;
      logic [7:0] unit_mask;
      logic [3:0] filter_mask;
   } hlec_config_type;

   typedef struct packed {
      logic       valid;
      logic [3:0] prior_state;
   } hlec_snoop_type;

   typedef struct packed {
      logic            valid;
      logic            write;
      hlec_source_type source;
   } hlec_request_type;

   // Unit mask bit for a request: two bits per source, read below write
   function automatic logic request_selected(input logic [7:0] umask,
                                             input hlec_request_type req);
      return umask[{req.source, req.write}];
   endfunction

   function automatic logic tracker_selected(input logic [7:0] umask, input int idx);
      return umask[idx];
   endfunction

endpackage

// *** core/hlec_conflict_table.sv ***
// Conflict address table: remembers which tracker entries are in conflict
`timescale 1ns/100ps
`default_nettype none
module hlec_conflict_table #(
   parameter int SLOTS   = 4,
   parameter int ENTRIES = 32
) (
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   input  wire logic                       join_valid,
   input  wire logic [$clog2(SLOTS)-1:0]   join_slot,
   input  wire logic [$clog2(ENTRIES)-1:0] join_entry,
   input  wire logic                       release_valid,
   input  wire logic [$clog2(SLOTS)-1:0]   release_slot,
   output var  logic                       dealloc_valid,
   output var  logic [1:0]                 dealloc_count
);
   import hlec_pkg::*;

   // Only tracker entry indices live here; requests stay in the tracker
   logic [ENTRIES-1:0] member   [SLOTS];
   logic [1:0]         conflicts[SLOTS];

   // ****************************************************************
   // Slot update
   // ****************************************************************
   for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            member[s]    <= '0;
            conflicts[s] <= CONFLICT_NONE;
         end else if (release_valid && release_slot == s) begin
            // Release beats a join in the same cycle: the slot is gone
            member[s]    <= '0;
            conflicts[s] <= CONFLICT_NONE;
         end else if (join_valid && join_slot == s && !member[s][join_entry]) begin
            member[s][join_entry] <= 1'b1;
            if (conflicts[s] != CONFLICT_SAT) begin
               conflicts[s] <= conflicts[s] + CONFLICT_STEP;
            end
         end
      end
   end

   // ****************************************************************
   // Deallocation report
   // ****************************************************************
   // Report at deallocation
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dealloc_valid <= 1'b0;
         dealloc_count <= CONFLICT_NONE;
      end else begin
         dealloc_valid <= release_valid && (member[release_slot] != '0);
         dealloc_count <= conflicts[release_slot];
      end
   end

   AST_CT_JOIN_MARKS : assert property (
      @(posedge clock) disable iff (sys_rst)
      (join_valid && !(release_valid && release_slot == join_slot))
      |=> member[$past(join_slot)][$past(join_entry)])
      else $error("Joined entry not recorded in slot");

   AST_CT_RELEASE_EMPTIES : assert property (
      @(posedge clock) disable iff (sys_rst)
      release_valid |=> (member[$past(release_slot)] == '0)
                        && (dealloc_valid == ($past(member[release_slot]) != '0)))
      else $error("Released slot not emptied or not reported");

endmodule // hlec_conflict_table
`default_nettype wire

// *** core/hlec_counter.sv ***
// Home logic performance event selection and counting
//
// Contract
// - Event 0c/08 counts remote invalidating snoops whose prior state passes filter.
// - Event 20 counts read requests: 01 io hub, 04 remote, 10 local.
// - Event 20 counts write requests: 02 io hub, 08 remote, 20 local.
// - Event 21 adds one per cycle the selected tracker is full.
// - Event 22 adds one per cycle the selected tracker is busy.
// - Event 23 accumulates read occupancy of selected tracker, allocation to deallocation.
// - Event 24/02 counts conflict entries with at most two conflicts at deallocation.
// - Conflict table holds only membership; requests stay in tracker entries.
`timescale 1ns/100ps
`default_nettype none
module hlec_counter #(
   parameter int COUNT_W       = 48,
   parameter int TRACKER_DEPTH = 32,
   parameter int CT_SLOTS      = 4
) (
   input  wire logic                             CLOCK,
   input  wire logic                             SYS_RST,
   input  wire hlec_pkg::hlec_config_type        CONFIG,
   input  wire hlec_pkg::hlec_snoop_type         SNOOP,
   input  wire hlec_pkg::hlec_request_type       REQUEST,
   input  wire logic [hlec_pkg::TRACKERS-1:0]    TRACKER_FULL,
   input  wire logic [hlec_pkg::TRACKERS-1:0]    TRACKER_BUSY,
   input  wire logic [hlec_pkg::TRACKERS-1:0]    READ_ALLOC,
   input  wire logic [hlec_pkg::TRACKERS-1:0]    READ_DEALLOC,
   input  wire logic                             CT_JOIN_VALID,
   input  wire logic [$clog2(CT_SLOTS)-1:0]      CT_JOIN_SLOT,
   input  wire logic [$clog2(TRACKER_DEPTH)-1:0] CT_JOIN_ENTRY,
   input  wire logic                             CT_RELEASE_VALID,
   input  wire logic [$clog2(CT_SLOTS)-1:0]      CT_RELEASE_SLOT,
   output var  logic [COUNT_W-1:0]               COUNT
);
   import hlec_pkg::*;

   localparam int             OCC_W   = $clog2(TRACKER_DEPTH + 1);
   localparam int             INC_W   = OCC_W + 2;
   localparam logic [INC_W-1:0] INC_ONE = INC_W'(1);

   logic [OCC_W-1:0] occupancy[TRACKERS];
   logic [INC_W-1:0] next_increment;
   logic             ct_dealloc_valid;
   logic [1:0]       ct_dealloc_count;

   // ****************************************************************
   // Conflict address table
   // ****************************************************************
   hlec_conflict_table #(
      .SLOTS   (CT_SLOTS),
      .ENTRIES (TRACKER_DEPTH)
   ) u_conflict_table (
      .clock         (CLOCK),
      .sys_rst       (SYS_RST),
      .join_valid    (CT_JOIN_VALID),
      .join_slot     (CT_JOIN_SLOT),
      .join_entry    (CT_JOIN_ENTRY),
      .release_valid (CT_RELEASE_VALID),
      .release_slot  (CT_RELEASE_SLOT),
      .dealloc_valid (ct_dealloc_valid),
      .dealloc_count (ct_dealloc_count)
   );

   // ****************************************************************
   // Read occupancy per tracker
   // ****************************************************************
   for (genvar t = 0; t < TRACKERS; t++) begin : g_occ
      always_ff @(posedge CLOCK) begin
         if (SYS_RST) begin
            occupancy[t] <= '0;
         end else begin
            occupancy[t] <= occupancy[t] + OCC_W'(READ_ALLOC[t]) - OCC_W'(READ_DEALLOC[t]);
         end
      end

      AST_OCC_TRACKS : assert property (
         @(posedge CLOCK) disable iff (SYS_RST)
         (READ_ALLOC[t] && !READ_DEALLOC[t]) |=> occupancy[t] == $past(occupancy[t]) + 1)
         else $error("Read occupancy did not grow on allocation");
   end

   // ****************************************************************
   // Event selection
   // ****************************************************************
   always_comb begin
      next_increment = '0;
      unique case (CONFIG.event_code)
         EV_SNOOP: begin
            if (CONFIG.unit_mask == UMASK_SNOOP_INVALIDATE && SNOOP.valid
                && (SNOOP.prior_state & CONFIG.filter_mask) != STATE_NONE) begin
               next_increment = INC_ONE;
            end
         end
         EV_REQUEST: begin
            if (REQUEST.valid && REQUEST.source <= SRC_LOCAL
                && request_selected(CONFIG.unit_mask, REQUEST)) begin
               next_increment = INC_ONE;
            end
         end
         EV_FULL: begin
            for (int i = 0; i < TRACKERS; i++) begin
               if (tracker_selected(CONFIG.unit_mask, i) && TRACKER_FULL[i]) begin
                  next_increment = next_increment + INC_ONE;
               end
            end
         end
         EV_BUSY: begin
            for (int i = 0; i < TRACKERS; i++) begin
               if (tracker_selected(CONFIG.unit_mask, i) && TRACKER_BUSY[i]) begin
                  next_increment = next_increment + INC_ONE;
               end
            end
         end
         EV_OCCUPANCY: begin
            for (int i = 0; i < TRACKERS; i++) begin
               if (tracker_selected(CONFIG.unit_mask, i)) begin
                  next_increment = next_increment + INC_W'(occupancy[i]);
               end
            end
         end
         EV_CONFLICT: begin
            if (CONFIG.unit_mask == UMASK_TWO_WAY && ct_dealloc_valid
                && ct_dealloc_count <= TWO_WAY_LIMIT) begin
               next_increment = INC_ONE;
            end
         end
         default: begin
            next_increment = '0;
         end
      endcase
   end

   // ****************************************************************
   // Counter
   // ****************************************************************
   // Wraps silently; overflow handling lives outside this block
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         COUNT <= '0;
      end else begin
         COUNT <= COUNT + COUNT_W'(next_increment);
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_SNOOP_COUNTS : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_SNOOP && CONFIG.unit_mask == UMASK_SNOOP_INVALIDATE
       && SNOOP.valid && (SNOOP.prior_state & CONFIG.filter_mask) != STATE_NONE)
      |=> COUNT == $past(COUNT) + 1)
      else $error("Filtered invalidating snoop not counted");

   AST_SNOOP_FILTERED : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_SNOOP && SNOOP.valid
       && (SNOOP.prior_state & CONFIG.filter_mask) == STATE_NONE)
      |=> $stable(COUNT))
      else $error("Snoop outside filter was counted");

   AST_READ_COUNTS : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_REQUEST && REQUEST.valid && !REQUEST.write
       && REQUEST.source == SRC_REMOTE && CONFIG.unit_mask == 8'h04)
      |=> COUNT == $past(COUNT) + 1)
      else $error("Remote read request not counted");

   AST_WRITE_COUNTS : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_REQUEST && REQUEST.valid && REQUEST.write
       && REQUEST.source == SRC_LOCAL && CONFIG.unit_mask == 8'h20)
      |=> COUNT == $past(COUNT) + 1)
      else $error("Local write request not counted");

   AST_WRITE_NOT_READ : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_REQUEST && REQUEST.valid && REQUEST.write
       && CONFIG.unit_mask == 8'h15)
      |=> $stable(COUNT))
      else $error("Write counted under a read-only mask");

   AST_FULL_RUN : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_FULL && CONFIG.unit_mask == 8'h02
       && TRACKER_FULL[1]) [*3]
      |=> COUNT == $past(COUNT, 3) + 3)
      else $error("Remote tracker full cycles miscounted");

   AST_BUSY_COUNTS : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_BUSY && CONFIG.unit_mask == 8'h05)
      |=> COUNT == $past(COUNT) + $past(TRACKER_BUSY[0]) + $past(TRACKER_BUSY[2]))
      else $error("Busy cycles miscounted");

   AST_OCC_ADDS : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_OCCUPANCY && CONFIG.unit_mask == 8'h04)
      |=> COUNT == $past(COUNT) + $past(occupancy[2]))
      else $error("Local read occupancy not accumulated");

   AST_CONFLICT_COUNTS : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code == EV_CONFLICT && CONFIG.unit_mask == UMASK_TWO_WAY
       && CT_RELEASE_VALID) ##1 (ct_dealloc_valid && ct_dealloc_count <= TWO_WAY_LIMIT
       && CONFIG.event_code == EV_CONFLICT && CONFIG.unit_mask == UMASK_TWO_WAY)
      |=> COUNT == $past(COUNT) + 1)
      else $error("Two-way conflict deallocation not counted");

   AST_OTHER_HOLDS : assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      (CONFIG.event_code < EV_REQUEST && CONFIG.event_code != EV_SNOOP) || CONFIG.event_code > EV_CONFLICT
      |=> $stable(COUNT))
      else $error("Counter moved under an unknown event code");

endmodule // hlec_counter
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking testbench for the home logic event counter
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import hlec_pkg::*;

   logic             clock;
   logic             sys_rst;
   hlec_config_type  cfg;
   hlec_snoop_type   snoop;
   hlec_request_type req;
   logic [2:0]       full;
   logic [2:0]       busy;
   logic [2:0]       alloc;
   logic [2:0]       dealloc;
   logic             join_valid;
   logic [1:0]       join_slot;
   logic [4:0]       join_entry;
   logic             rel_valid;
   logic [1:0]       rel_slot;
   logic [47:0]      count;
   logic [47:0]      base;
   int               mismatches;
   int               n_tests;

   hlec_counter #(.COUNT_W(48), .TRACKER_DEPTH(32), .CT_SLOTS(4)) dut_u (
      .CLOCK(clock), .SYS_RST(sys_rst), .CONFIG(cfg), .SNOOP(snoop), .REQUEST(req),
      .TRACKER_FULL(full), .TRACKER_BUSY(busy), .READ_ALLOC(alloc), .READ_DEALLOC(dealloc),
      .CT_JOIN_VALID(join_valid), .CT_JOIN_SLOT(join_slot), .CT_JOIN_ENTRY(join_entry),
      .CT_RELEASE_VALID(rel_valid), .CT_RELEASE_SLOT(rel_slot), .COUNT(count));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic check(input string what, input logic [47:0] expected, input logic [47:0] seen);
      n_tests++;
      if (seen !== expected) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, expected, seen);
      end
   endtask

   // Base taken after the edge so the new selection alone is measured
   task automatic set_cfg(input logic [7:0] ev, input logic [7:0] um, input logic [3:0] fm);
      @(posedge clock);
      cfg <= '{ev, um, fm};
      step(2);
      #1 base = count;
      // Back on an edge so callers drive by NBA at the rising edge
      @(posedge clock);
   endtask

   task automatic delta(input string what, input logic [47:0] expected);
      step(4);
      #1 check(what, expected, count - base);
   endtask

   task automatic snoop_pulse(input logic [3:0] st);
      @(posedge clock);
      snoop <= '{1'b1, st};
      @(posedge clock);
      snoop <= '{1'b0, STATE_NONE};
   endtask

   task automatic ct_op(input logic j, input logic [1:0] js, input logic [4:0] je,
                        input logic r, input logic [1:0] rs);
      @(posedge clock);
      join_valid <= j;
      join_slot <= js;
      join_entry <= je;
      rel_valid <= r;
      rel_slot <= rs;
   endtask

   task automatic close_out();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_reset();
      set_cfg(EV_FULL, 8'h01, 4'h0);
      full <= 3'b001;
      step(3);
      sys_rst <= 1'b1;
      step(2);
      #1 check("count in reset", 48'h0, count);
      @(posedge clock);
      sys_rst <= 1'b0;
      full <= 3'b000;
   endtask

   task automatic test_snoop();
      logic [3:0] st [3] = '{STATE_MODIFIED, STATE_SHARED, STATE_FORWARD};
      for (int i = 0; i < 3; i++) begin
         set_cfg(EV_SNOOP, UMASK_SNOOP_INVALIDATE, st[i]);
         snoop_pulse(STATE_MODIFIED);
         snoop_pulse(STATE_SHARED);
         snoop_pulse(STATE_FORWARD);
         snoop_pulse(st[i]);
         delta("snoop filtered", 48'h2);
      end
      set_cfg(EV_SNOOP, 8'h02, STATE_FORWARD);
      snoop_pulse(STATE_FORWARD);
      delta("snoop other umask", 48'h0);
   endtask

   // Every source and direction, back to back, source 3 included
   task automatic test_requests();
      logic [7:0]  masks [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h3f, 8'hc0,
                                 8'h15};
      logic [47:0] exp_n [9] = '{48'h1, 48'h1, 48'h1, 48'h1, 48'h1, 48'h1, 48'h6, 48'h0,
                                 48'h3};
      for (int i = 0; i < 9; i++) begin
         set_cfg(EV_REQUEST, masks[i], 4'h0);
         for (int s = 0; s < 4; s++) begin
            for (int w = 0; w < 2; w++) begin
               @(posedge clock);
               req <= '{1'b1, w[0], hlec_source_type'(s)};
            end
         end
         @(posedge clock);
         req <= '{1'b0, 1'b0, SRC_IO_HUB};
         delta("request count", exp_n[i]);
      end
   endtask

   // All trackers active 3 cycles, io hub tracker 3 more
   task automatic test_levels(input logic [7:0] ev, input logic is_busy);
      logic [7:0]  masks [5] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h05};
      logic [47:0] exp_n [5] = '{48'h6, 48'h3, 48'h3, 48'hc, 48'h9};
      for (int i = 0; i < 5; i++) begin
         set_cfg(ev, masks[i], 4'h0);
         if (is_busy) busy <= 3'b111;
         else full <= 3'b111;
         step(2);
         @(posedge clock);
         if (is_busy) busy <= 3'b001;
         else full <= 3'b001;
         step(2);
         @(posedge clock);
         busy <= 3'b000;
         full <= 3'b000;
         delta("tracker cycles", exp_n[i]);
      end
   endtask

   // Local holds 1 then 2 entries; io hub holds one entry for 6 cycles
   task automatic test_occupancy();
      logic [7:0]  masks [3] = '{8'h04, 8'h01, 8'h05};
      logic [47:0] exp_n [3] = '{48'hc, 48'h6, 48'h12};
      for (int i = 0; i < 3; i++) begin
         set_cfg(EV_OCCUPANCY, masks[i], 4'h0);
         @(posedge clock);
         alloc <= 3'b101;
         @(posedge clock);
         alloc <= 3'b100;
         @(posedge clock);
         alloc <= 3'b000;
         step(3);
         @(posedge clock);
         dealloc <= 3'b101;
         @(posedge clock);
         dealloc <= 3'b100;
         @(posedge clock);
         dealloc <= 3'b000;
         delta("read occupancy", exp_n[i]);
      end
   endtask

   task automatic test_conflict(input logic [7:0] um, input logic [47:0] expected);
      set_cfg(EV_CONFLICT, um, 4'h0);
      // Duplicate entry joins once: two members
      ct_op(1'b1, 2'd0, 5'd3, 1'b0, 2'd0);
      ct_op(1'b1, 2'd0, 5'd5, 1'b0, 2'd0);
      ct_op(1'b1, 2'd0, 5'd3, 1'b0, 2'd0);
      ct_op(1'b1, 2'd1, 5'd1, 1'b1, 2'd0);
      // Join lost to a release of the same slot
      ct_op(1'b1, 2'd1, 5'd2, 1'b0, 2'd0);
      ct_op(1'b1, 2'd1, 5'd9, 1'b1, 2'd1);
      ct_op(1'b1, 2'd2, 5'd3, 1'b0, 2'd0);
      ct_op(1'b1, 2'd2, 5'd4, 1'b0, 2'd0);
      ct_op(1'b1, 2'd2, 5'd6, 1'b0, 2'd0);
      ct_op(1'b0, 2'd0, 5'd0, 1'b1, 2'd2);
      // Empty slot reports nothing
      ct_op(1'b0, 2'd0, 5'd0, 1'b1, 2'd3);
      ct_op(1'b0, 2'd0, 5'd0, 1'b0, 2'd0);
      delta("conflict count", expected);
   endtask

   // Unknown code with all trackers full and busy and a snoop active
   task automatic test_unknown();
      set_cfg(8'h25, 8'hff, 4'hf);
      full <= 3'b111;
      busy <= 3'b111;
      snoop_pulse(STATE_MODIFIED);
      full <= 3'b000;
      busy <= 3'b000;
      delta("unknown code", 48'h0);
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      mismatches = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      cfg = '0;
      snoop = '0;
      req = '0;
      full = 3'b000;
      busy = 3'b000;
      alloc = 3'b000;
      dealloc = 3'b000;
      join_valid = 1'b0;
      join_slot = 2'd0;
      join_entry = 5'd0;
      rel_valid = 1'b0;
      rel_slot = 2'd0;
      step(12);
      sys_rst <= 1'b0;
      #1 check("count after reset", 48'h0, count);
      test_snoop();
      test_requests();
      test_levels(EV_FULL, 1'b0);
      test_levels(EV_BUSY, 1'b1);
      test_occupancy();
      test_conflict(UMASK_TWO_WAY, 48'h2);
      test_conflict(8'h04, 48'h0);
      test_unknown();
      test_reset();
      test_snoop();
      close_out();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      step(20000);
      mismatches++;
      close_out();
   end

endmodule // testbench
`default_nettype wire
